// *** src/sldrp_params.svh ***
`ifndef SLDRP_PARAMS_SVH
`define SLDRP_PARAMS_SVH
`define SLDRP_PKT_BITS 16
`define SLDRP_ADDR_HI 11
`define SLDRP_ADDR_LO 8
`define SLDRP_DATA_HI 7
`define SLDRP_DATA_LO 0
`define SLDRP_A_NOOP 4'h0
`define SLDRP_A_DIG0 4'h1
`define SLDRP_A_DIG3 4'h4
`define SLDRP_A_DECODE 4'h9
`define SLDRP_A_INTENS 4'hA
`define SLDRP_A_SCAN 4'hB
`define SLDRP_A_SHDN 4'hC
`define SLDRP_A_RSTCLK 4'hE
`define SLDRP_A_TEST 4'hF
`define SLDRP_SHDN_BIT 0
`define SLDRP_RST_BYTE 8'h00
`define SLDRP_WAKE_US 250
`define SLDRP_CLK_MHZ 200
`define SLDRP_SCAN_TICKS 16'h0400
`define SLDRP_SEG_OFF 8'h00
`define SLDRP_SEG_ALL 8'hFF
`define SLDRP_DIG_OFF 4'hF
`define SLDRP_DP_BIT 7
`endif

// *** src/sldrp_pkg.sv ***
package sldrp_pkg;
  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] data;
  } sldrp_wr_s;
  typedef struct packed {
    logic [7:0] seg;
    logic [3:0] dig_n;
  } sldrp_drv_s;
  typedef enum logic [1:0] {
    SLDRP_OFF = 2'b00,
    SLDRP_WAKE = 2'b01,
    SLDRP_RUN = 2'b10
  } sldrp_pwr_e;
endpackage

// *** src/sldrp_font.sv ***
`timescale 1ns/100ps
`include "sldrp_params.svh"
module sldrp_font
  import sldrp_pkg::*;
(
  input wire logic [7:0] data, // Digit register contents
  input wire logic decode, // Route through code-B decoder
  output logic [7:0] seg // {dp,a,b,c,d,e,f,g}
);
  logic [6:0] glyph;

  always_comb
  begin
    unique case (data[3:0])
      4'h0: glyph = 7'h7E;
      4'h1: glyph = 7'h30;
      4'h2: glyph = 7'h6D;
      4'h3: glyph = 7'h79;
      4'h4: glyph = 7'h33;
      4'h5: glyph = 7'h5B;
      4'h6: glyph = 7'h5F;
      4'h7: glyph = 7'h70;
      4'h8: glyph = 7'h7F;
      4'h9: glyph = 7'h7B;
      4'hA: glyph = 7'h01;
      4'hB: glyph = 7'h4F;
      4'hC: glyph = 7'h37;
      4'hD: glyph = 7'h0E;
      4'hE: glyph = 7'h67;
      4'hF: glyph = 7'h00;
    endcase
  end

  // Decimal point passes untouched in both modes
  assign seg = {data[`SLDRP_DP_BIT],
                decode ? glyph : data[6:0]};
endmodule // sldrp_font

// *** src/sldrp_top.sv ***
//Contract
// - 16-bit packets shift in on rising clock
// - Load rising edge writes addressed register
// - Output delayed 16.5 cycles, falling edge
// - MSB first; D11-D8 address, D7-D0 data
// - Nine registers chosen by 4-bit address
// - Digit write changes only that digit
// - Shutdown blanks segments, digits driven high
// - Shutdown keeps digit register contents
// - Leaving shutdown takes 250 us
// - Writes still accepted during shutdown
// - Display test alone overrides shutdown
// - Power-up resets registers, starts in shutdown
// - Defaults: one digit, no decode, minimums
// - Decode register bit per digit enables decoder
// - Decode bit zero sends raw data
// - D7 drives decimal point always; test mode forces it on, shutdown forces it off
// - Decoder shows 0-9, E, H, L, P, dash
`timescale 1ns/100ps
`include "sldrp_params.svh"
module sldrp_top
  import sldrp_pkg::*;
#(
  parameter int WAKE_CYCLES = `SLDRP_WAKE_US * `SLDRP_CLK_MHZ,
  parameter logic [15:0] SCAN_TICKS = `SLDRP_SCAN_TICKS
)
(
  input wire logic SYS_CLK, // Core clock, 200 MHz
  input wire logic RESETN, // Asynchronous reset, active low
  input wire logic SER_CLK, // Serial clock from host
  input wire logic SER_DIN, // Serial data in
  input wire logic SER_LOAD, // Load strobe
  output logic SER_DOUT, // Serial data out for cascading
  output logic [7:0] SEGMENT_LINES, // {dp,a..g}, high lights
  output logic [3:0] DIGIT_SINK_LINES, // Low selects a digit
  output logic DECIMAL_POINT_SEGMENT, // Copy of segment dp
  output logic [3:0] INTENSITY, // Intensity register
  output logic SHUTDOWN_ACTIVE // Display blanked by shutdown
);
  import sldrp_pkg::*;

  localparam int WAKE_W = $clog2(WAKE_CYCLES + 1);

  // Link clock domain: shift register and cascade output
  logic [15:0] shift_q;
  logic dly_q;
  logic dout_q;

  always_ff @(posedge SER_CLK or negedge RESETN)
  begin
    if (!RESETN)
      shift_q <= 16'h0000;
    else
      shift_q <= {shift_q[14:0], SER_DIN};
  end

  // Bit leaves the shifter after 16 rises, shown at the next fall
  always_ff @(posedge SER_CLK or negedge RESETN)
  begin
    if (!RESETN)
      dly_q <= 1'b0;
    else
      dly_q <= shift_q[`SLDRP_PKT_BITS-1];
  end

  always_ff @(negedge SER_CLK or negedge RESETN)
  begin
    if (!RESETN)
      dout_q <= 1'b0;
    else
      dout_q <= dly_q;
  end

  assign SER_DOUT = dout_q;

  // Load edge captures the packet in the link domain; the serial clock
  // may stop after it, so the word must be held here, not re-sampled.
  logic [11:0] pkt_q;
  logic load_tgl_q;

  always_ff @(posedge SER_LOAD or negedge RESETN)
  begin
    if (!RESETN)
      pkt_q <= 12'h000;
    else
      pkt_q <= shift_q[`SLDRP_ADDR_HI:`SLDRP_DATA_LO];
  end

  always_ff @(posedge SER_LOAD or negedge RESETN)
  begin
    if (!RESETN)
      load_tgl_q <= 1'b0;
    else
      load_tgl_q <= ~load_tgl_q;
  end

  // Toggle crossing: three stages, change counts when 2nd and 3rd differ
  logic [2:0] tgl_sync_q;
  logic load_evt;
  sldrp_wr_s wr;

  always_ff @(posedge SYS_CLK or negedge RESETN)
  begin
    if (!RESETN)
      tgl_sync_q <= 3'b000;
    else
      tgl_sync_q <= {tgl_sync_q[1:0], load_tgl_q};
  end

  assign load_evt = tgl_sync_q[2] ^ tgl_sync_q[1];
  // Packet held stable for at least two core cycles before the toggle lands
  assign wr = sldrp_wr_s'(pkt_q);

  // Register file
  logic [7:0] digit_q [4];
  logic [7:0] decode_q;
  logic [3:0] intens_q;
  logic [2:0] scan_q;
  logic test_q;
  logic run_q;

  function automatic logic hit(input logic [3:0] a, input logic [3:0] b);
    hit = load_evt && (a == b) && (a != `SLDRP_A_NOOP);
  endfunction

  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++)
    begin : g_dig
      always_ff @(posedge SYS_CLK or negedge RESETN)
      begin
        if (!RESETN)
          digit_q[gi] <= `SLDRP_RST_BYTE;
        else if (hit(wr.addr, 4'(`SLDRP_A_DIG0 + gi)))
          digit_q[gi] <= wr.data;
      end
    end
  endgenerate

  always_ff @(posedge SYS_CLK or negedge RESETN)
  begin
    if (!RESETN)
      decode_q <= `SLDRP_RST_BYTE;
    else if (hit(wr.addr, `SLDRP_A_DECODE))
      decode_q <= wr.data;
  end

  always_ff @(posedge SYS_CLK or negedge RESETN)
  begin
    if (!RESETN)
      intens_q <= 4'h0;
    else if (hit(wr.addr, `SLDRP_A_INTENS))
      intens_q <= wr.data[3:0];
  end

  always_ff @(posedge SYS_CLK or negedge RESETN)
  begin
    if (!RESETN)
      scan_q <= 3'h0;
    else if (hit(wr.addr, `SLDRP_A_SCAN))
      scan_q <= wr.data[2:0];
  end

  always_ff @(posedge SYS_CLK or negedge RESETN)
  begin
    if (!RESETN)
      test_q <= 1'b0;
    else if (hit(wr.addr, `SLDRP_A_TEST))
      test_q <= wr.data[0];
  end

  always_ff @(posedge SYS_CLK or negedge RESETN)
  begin
    if (!RESETN)
      run_q <= 1'b0;
    else if (hit(wr.addr, `SLDRP_A_SHDN))
      run_q <= wr.data[`SLDRP_SHDN_BIT];
  end

  // Power state: wake delay after leaving shutdown
  sldrp_pwr_e pwr_q;
  logic [WAKE_W-1:0] wake_q;

  always_ff @(posedge SYS_CLK or negedge RESETN)
  begin
    if (!RESETN)
      pwr_q <= SLDRP_OFF;
    else
      unique case (pwr_q)
        SLDRP_OFF: if (run_q) pwr_q <= SLDRP_WAKE;
        SLDRP_WAKE:
          if (!run_q)
            pwr_q <= SLDRP_OFF;
          else if (wake_q == WAKE_W'(WAKE_CYCLES - 1))
            pwr_q <= SLDRP_RUN;
        SLDRP_RUN: if (!run_q) pwr_q <= SLDRP_OFF;
        default: pwr_q <= SLDRP_OFF;
      endcase
  end

  always_ff @(posedge SYS_CLK or negedge RESETN)
  begin
    if (!RESETN)
      wake_q <= '0;
    else if (pwr_q == SLDRP_WAKE)
      wake_q <= wake_q + 1'b1;
    else
      wake_q <= '0;
  end

  // Scan: step through digits 0..scan limit
  logic [15:0] tick_q;
  logic [1:0] cur_q;
  logic [2:0] lim;

  assign lim = (scan_q > 3'h3) ? 3'h3 : scan_q;

  always_ff @(posedge SYS_CLK or negedge RESETN)
  begin
    if (!RESETN)
      tick_q <= 16'h0000;
    else if (tick_q == SCAN_TICKS - 16'h0001)
      tick_q <= 16'h0000;
    else
      tick_q <= tick_q + 16'h0001;
  end

  always_ff @(posedge SYS_CLK or negedge RESETN)
  begin
    if (!RESETN)
      cur_q <= 2'h0;
    else if (tick_q == SCAN_TICKS - 16'h0001)
      cur_q <= ({1'b0, cur_q} >= lim) ? 2'h0 : cur_q + 2'h1;
  end

  logic [7:0] seg_now;

  sldrp_font u_font (
    .data(digit_q[cur_q]),
    .decode(decode_q[cur_q]),
    .seg(seg_now)
  );

  // Drivers registered so outputs come straight from flip-flops
  sldrp_drv_s drv_q;

  always_ff @(posedge SYS_CLK or negedge RESETN)
  begin
    if (!RESETN)
      drv_q <= '{seg: `SLDRP_SEG_OFF, dig_n: `SLDRP_DIG_OFF};
    else if (test_q)
      drv_q <= '{seg: `SLDRP_SEG_ALL, dig_n: 4'h0};
    else if (pwr_q != SLDRP_RUN)
      drv_q <= '{seg: `SLDRP_SEG_OFF, dig_n: `SLDRP_DIG_OFF};
    else
      drv_q <= '{seg: seg_now, dig_n: ~(4'h1 << cur_q)};
  end

  always_ff @(posedge SYS_CLK or negedge RESETN)
  begin
    if (!RESETN)
      SHUTDOWN_ACTIVE <= 1'b1;
    else
      SHUTDOWN_ACTIVE <= (pwr_q != SLDRP_RUN) && !test_q;
  end

  always_ff @(posedge SYS_CLK or negedge RESETN)
  begin
    if (!RESETN)
      INTENSITY <= 4'h0;
    else
      INTENSITY <= intens_q;
  end

  assign SEGMENT_LINES = drv_q.seg;
  assign DIGIT_SINK_LINES = drv_q.dig_n;
  assign DECIMAL_POINT_SEGMENT = drv_q.seg[`SLDRP_DP_BIT];
endmodule // sldrp_top

// *** test/sldrp_host.sv ***
`timescale 1ns/100ps
module sldrp_host
(
  output logic ser_clk, // Serial clock, still between frames
  output logic ser_din, // Serial data
  output logic ser_load, // Load strobe
  input wire logic ser_dout, // Cascade output of the device
  output logic [15:0] cap // Cascade bits seen at each rise
);
  initial
  begin
    ser_clk = 1'b0;
    ser_din = 1'b0;
    ser_load = 1'b0;
    cap = 16'h0000;
  end
  task automatic send(input logic [15:0] pkt);
    for (int i = 15; i >= 0; i--)
    begin
      ser_din = pkt[i];
      #16 ser_clk = 1'b1;
      cap = {cap[14:0], ser_dout};
      #16 ser_clk = 1'b0;
    end
    // Data line left toggled so a stale bit never looks valid
    ser_din = ~pkt[0];
    #8 ser_load = 1'b1;
    #56 ser_load = 1'b0;
    #40;
  endtask
endmodule // sldrp_host

// *** test/sldrp_assertions.sv ***
`timescale 1ns/100ps
module sldrp_assertions
#(
  parameter int WAKE_CYCLES = 20,
  parameter logic [15:0] SCAN_TICKS = 16'h0004
)
(
  input wire logic SYS_CLK, // Core clock
  input wire logic RESETN, // Reset, active low
  input wire logic SER_CLK, // Serial clock
  input wire logic SER_DIN, // Serial data
  input wire logic SER_LOAD, // Load strobe
  input wire logic SER_DOUT, // Cascade out
  input wire logic [7:0] SEGMENT_LINES, // Segments
  input wire logic [3:0] DIGIT_SINK_LINES, // Digit sinks
  input wire logic DECIMAL_POINT_SEGMENT, // Point copy
  input wire logic [3:0] INTENSITY, // Intensity
  input wire logic SHUTDOWN_ACTIVE // Blanked flag
);
  logic load_q;
  logic [15:0] since_q;
  logic [4:0] rises_q;
  // Cycles since the last load rise, saturating
  always_ff @(posedge SYS_CLK or negedge RESETN)
    if (!RESETN)
      since_q <= 16'hFFFF;
    else if (SER_LOAD && !load_q)
      since_q <= 16'h0000;
    else if (since_q != 16'hFFFF)
      since_q <= since_q + 16'h0001;
  always_ff @(posedge SYS_CLK or negedge RESETN)
    if (!RESETN)
      load_q <= 1'b0;
    else
      load_q <= SER_LOAD;
  // Cascade check waits until the shift path is full
  always_ff @(posedge SER_CLK or negedge RESETN)
    if (!RESETN)
      rises_q <= 5'h00;
    else if (rises_q != 5'h11)
      rises_q <= rises_q + 5'h01;
  sequence s_held;
    SHUTDOWN_ACTIVE [*3];
  endsequence
  a_point_copy: assert property (@(posedge SYS_CLK)
    disable iff (!RESETN) DECIMAL_POINT_SEGMENT == SEGMENT_LINES[7])
    else $error("point differs from segment bit");
  a_shdn_blank: assert property (@(posedge SYS_CLK)
    disable iff (!RESETN) s_held |-> SEGMENT_LINES == 8'hFF ||
    (SEGMENT_LINES == 8'h00 && DIGIT_SINK_LINES == 4'hF))
    else $error("display lit during shutdown");
  a_reset_dark: assert property (@(posedge SYS_CLK)
    disable iff (!RESETN) $rose(RESETN) |->
    SHUTDOWN_ACTIVE && INTENSITY == 4'h0)
    else $error("wrong state after reset");
  a_dout_delay: assert property (@(posedge SER_CLK)
    disable iff (!RESETN) rises_q == 5'h11 |->
    SER_DOUT == $past(SER_DIN, 17))
    else $error("cascade bit delay wrong");
  a_dout_steady: assert property (@(posedge SYS_CLK)
    disable iff (!RESETN) $changed(SER_DOUT) |-> !SER_CLK)
    else $error("cascade out moved with clock high");
  a_intens_cause: assert property (@(posedge SYS_CLK)
    disable iff (!RESETN) $changed(INTENSITY) |-> since_q <= 16'h000A)
    else $error("intensity changed without load");
  a_shdn_cause: assert property (@(posedge SYS_CLK)
    disable iff (!RESETN) $rose(SHUTDOWN_ACTIVE) |-> since_q <= 16'h000A)
    else $error("shutdown entered without load");
  // Test mode also clears the flag at once, but it sinks every digit
  a_wake_time: assert property (@(posedge SYS_CLK)
    disable iff (!RESETN) $fell(SHUTDOWN_ACTIVE) &&
    DIGIT_SINK_LINES != 4'h0 |-> since_q >= WAKE_CYCLES)
    else $error("shutdown left too early");
endmodule // sldrp_assertions
bind sldrp_top sldrp_assertions #(
  .WAKE_CYCLES(WAKE_CYCLES),
  .SCAN_TICKS(SCAN_TICKS)
) u_chk (
  .SYS_CLK(SYS_CLK),
  .RESETN(RESETN),
  .SER_CLK(SER_CLK),
  .SER_DIN(SER_DIN),
  .SER_LOAD(SER_LOAD),
  .SER_DOUT(SER_DOUT),
  .SEGMENT_LINES(SEGMENT_LINES),
  .DIGIT_SINK_LINES(DIGIT_SINK_LINES),
  .DECIMAL_POINT_SEGMENT(DECIMAL_POINT_SEGMENT),
  .INTENSITY(INTENSITY),
  .SHUTDOWN_ACTIVE(SHUTDOWN_ACTIVE)
);

// *** test/sldrp_top_bench.sv ***
`timescale 1ns/100ps
module sldrp_top_bench;
  localparam int WAKE = 60;
  logic SYS_CLK;
  logic RESETN;
  logic SER_CLK;
  logic SER_DIN;
  logic SER_LOAD;
  logic SER_DOUT;
  logic [7:0] SEGMENT_LINES;
  logic [3:0] DIGIT_SINK_LINES;
  logic [3:0] INTENSITY;
  logic SHUTDOWN_ACTIVE;
  logic DECIMAL_POINT_SEGMENT;
  logic [15:0] cap;
  logic [15:0] view;
  int n_fail;
  int checked;
  int cycles;
  // Rows: decode byte, digit data, expected segments
  logic [23:0] rows [18] = '{24'h01007E, 24'h010130, 24'h01026D,
    24'h010379, 24'h010433, 24'h01055B, 24'h01065F, 24'h010770,
    24'h01087F, 24'h018A81, 24'h01797B, 24'h010B4F, 24'h010C37,
    24'h010D0E, 24'h010E67, 24'h010F00, 24'h005A5A, 24'hFE8585};
  assign view = {SEGMENT_LINES, DIGIT_SINK_LINES, INTENSITY};
  sldrp_top #(.WAKE_CYCLES(WAKE), .SCAN_TICKS(16'h0004)) u_dut (
    .SYS_CLK(SYS_CLK), .RESETN(RESETN), .SER_CLK(SER_CLK),
    .SER_DIN(SER_DIN), .SER_LOAD(SER_LOAD), .SER_DOUT(SER_DOUT),
    .SEGMENT_LINES(SEGMENT_LINES), .DIGIT_SINK_LINES(DIGIT_SINK_LINES),
    .DECIMAL_POINT_SEGMENT(DECIMAL_POINT_SEGMENT), .INTENSITY(INTENSITY),
    .SHUTDOWN_ACTIVE(SHUTDOWN_ACTIVE));
  sldrp_host u_host (.ser_clk(SER_CLK), .ser_din(SER_DIN),
    .ser_load(SER_LOAD), .ser_dout(SER_DOUT), .cap(cap));
  initial
  begin
    SYS_CLK = 1'b0;
    forever #2.5 SYS_CLK = ~SYS_CLK;
  end
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp)
    begin
      n_fail++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic put(input logic [15:0] pkt);
    u_host.send(pkt);
    repeat (12) @(posedge SYS_CLK);
    @(negedge SYS_CLK);
  endtask
  // Scan moves every few cycles: wait for the digit, then compare
  task automatic show(input logic [3:0] dig, input logic [7:0] seg);
    int n;
    n = 0;
    while (DIGIT_SINK_LINES !== dig && n < 32)
    begin
      @(negedge SYS_CLK);
      n++;
    end
    chk(view, {seg, dig, 4'h3});
  endtask
  task automatic final_report;
    $display("checked=%0d n_fail=%0d", checked, n_fail);
    if (n_fail == 0 && checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  always @(posedge SYS_CLK)
  begin
    cycles++;
    if (cycles == 30000)
    begin
      n_fail++;
      final_report();
    end
  end
  initial
  begin
    RESETN = 1'b0;
    n_fail = 0;
    checked = 0;
    cycles = 0;
    repeat (8) @(posedge SYS_CLK);
    RESETN <= 1'b1;
    repeat (2) @(negedge SYS_CLK);
    chk({15'h0000, SHUTDOWN_ACTIVE}, 16'h0001);
    chk(view, 16'h00F0);
    put(16'hF15A);
    chk(view, 16'h00F0);
    put(16'h0C01);
    chk(view, 16'h00F0);
    repeat (WAKE) @(negedge SYS_CLK);
    chk(view, 16'h5AE0);
    chk({15'h0000, SHUTDOWN_ACTIVE}, 16'h0000);
    put(16'h0AF3);
    chk(view, 16'h5AE3);
    foreach (rows[i])
    begin
      put({8'h09, rows[i][23:16]});
      put({8'h01, rows[i][15:8]});
      chk(view, {rows[i][7:0], 8'hE3});
      chk({15'h0000, DECIMAL_POINT_SEGMENT}, {15'h0000, rows[i][7]});
    end
    put(16'h0233);
    put(16'h0344);
    put(16'h0455);
    chk(view, 16'h85E3);
    put(16'h0011);
    chk(view, 16'h85E3);
    chk({1'b0, cap[14:0]}, 16'h022A);
    put(16'h0B03);
    show(4'hE, 8'h85);
    show(4'hD, 8'h79);
    show(4'hB, 8'h33);
    show(4'h7, 8'h5B);
    put(16'h0B00);
    put(16'h0F01);
    chk({8'h00, SEGMENT_LINES}, 16'h00FF);
    put(16'h0C00);
    chk({8'h00, SEGMENT_LINES}, 16'h00FF);
    put(16'h0F00);
    chk(view, 16'h00F3);
    put(16'h0C01);
    repeat (WAKE) @(negedge SYS_CLK);
    chk(view, 16'h85E3);
    // Second reset in mid-run, with registers programmed
    @(posedge SYS_CLK);
    RESETN <= 1'b0;
    repeat (2) @(negedge SYS_CLK);
    chk(view, 16'h00F0);
    @(posedge SYS_CLK);
    RESETN <= 1'b1;
    repeat (2) @(negedge SYS_CLK);
    chk({15'h0000, SHUTDOWN_ACTIVE}, 16'h0001);
    put(16'h0C01);
    repeat (WAKE) @(negedge SYS_CLK);
    chk(view, 16'h00E0);
    final_report();
  end
endmodule // sldrp_top_bench
